// >>> src/fcs_host.sv
// Host sequencer that drives the flash command bus.
`timescale 1ns/10ps
`default_nettype none
module fcs_host #(
  parameter int DE_CYCLES  = fcs_pkg::DE_CYC,
  parameter int DAP_LIMIT  = fcs_pkg::DAP_CYC,
  parameter int DAE_LIMIT  = fcs_pkg::DAE_CYC,
  parameter logic [7:0] AUTO_PRG_CODE = fcs_pkg::CMD_AUTO_PRG_B
) (
  input  wire logic                        mclk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        cmd_valid_i,
  input  wire fcs_pkg::fcs_op_type         cmd_op_i,
  input  wire logic [fcs_pkg::ADDR_W-1:0]  cmd_addr_i,
  input  wire logic [fcs_pkg::DATA_W-1:0]  cmd_data_i,
  output var  logic                        busy_o,
  output var  logic                        done_o,
  output var  logic                        fail_o,
  output var  logic [fcs_pkg::DATA_W-1:0]  rdata_o,
  output var  logic [fcs_pkg::ADDR_W-1:0]  fl_addr_o,
  output var  logic [fcs_pkg::DATA_W-1:0]  fl_dq_o,
  output var  logic                        fl_dq_oe_o,
  input  wire logic [fcs_pkg::DATA_W-1:0]  fl_dq_i,
  output var  logic                        fl_ce_n_o,
  output var  logic                        fl_oe_n_o,
  output var  logic                        fl_we_n_o,
  output var  logic                        fl_vpp_o
);

  localparam int TW = fcs_pkg::TMR_W;
  localparam int DW = fcs_pkg::DATA_W;
  localparam int AW = fcs_pkg::ADDR_W;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_pipe;
  logic [1:0] next_rst_pipe;
  logic       rst_n;

  assign rst_n = rst_pipe[1];

  always_comb
  begin
    next_rst_pipe = {rst_pipe[0], 1'b1};
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_pipe <= 2'h0;
    end
    else
    begin
      rst_pipe <= next_rst_pipe;
    end
  end

  // ----------------------------------------------------------------
  // Data input synchroniser and timers
  // ----------------------------------------------------------------
  logic [DW-1:0] dq_sync;
  logic          tmr_load;
  logic [TW-1:0] tmr_count;
  logic          tmr_exp;
  logic          poll_load;
  logic [TW-1:0] poll_count;
  logic          poll_exp;

  fcs_sync #(
    .WIDTH (DW)
  ) u_dq_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n),
    .din_i   (fl_dq_i),
    .dout_o  (dq_sync)
  );

  fcs_timer #(
    .WIDTH (TW)
  ) u_step_tmr (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n),
    .load_i    (tmr_load),
    .count_i   (tmr_count),
    .expired_o (tmr_exp)
  );

  fcs_timer #(
    .WIDTH (TW)
  ) u_poll_tmr (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n),
    .load_i    (poll_load),
    .count_i   (poll_count),
    .expired_o (poll_exp)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  fcs_pkg::fcs_state_type state;
  fcs_pkg::fcs_state_type next_state;
  fcs_pkg::fcs_rd_type    rkind;
  fcs_pkg::fcs_rd_type    next_rkind;
  logic [7:0]    cmd1;
  logic [7:0]    next_cmd1;
  logic [DW-1:0] wr2_data;
  logic [DW-1:0] next_wr2_data;
  logic          two_wr;
  logic          next_two_wr;
  logic          second;
  logic          next_second;
  logic          fail_flag;
  logic          next_fail_flag;
  logic [TW-1:0] post_wait;
  logic [TW-1:0] next_post_wait;
  logic [TW-1:0] poll_limit;
  logic [TW-1:0] next_poll_limit;
  logic          next_busy;
  logic          next_done;
  logic          next_fail;
  logic [DW-1:0] next_rdata;
  logic [AW-1:0] next_addr;
  logic [DW-1:0] next_dq;
  logic          next_dq_oe;
  logic          next_ce_n;
  logic          next_oe_n;
  logic          next_we_n;
  logic          next_vpp;
  logic          wr_state;

  always_comb
  begin
    next_state      = state;
    next_rkind      = rkind;
    next_cmd1       = cmd1;
    next_wr2_data   = wr2_data;
    next_two_wr     = two_wr;
    next_second     = second;
    next_fail_flag  = fail_flag;
    next_post_wait  = post_wait;
    next_poll_limit = poll_limit;
    next_busy       = busy_o;
    next_done       = 1'b0;
    next_fail       = 1'b0;
    next_rdata      = rdata_o;
    next_addr       = fl_addr_o;
    next_vpp        = fl_vpp_o;
    tmr_load        = 1'b0;
    tmr_count       = '0;
    poll_load       = 1'b0;
    poll_count      = '0;
    case (state)
      fcs_pkg::FCS_ST_IDLE:
      begin
        if (cmd_valid_i)
        begin
          next_busy       = 1'b1;
          next_second     = 1'b0;
          next_fail_flag  = 1'b0;
          next_addr       = cmd_addr_i;
          next_wr2_data   = cmd_data_i;
          next_two_wr     = 1'b0;
          next_rkind      = fcs_pkg::FCS_RD_NONE;
          // Reads after a write wait out the recovery time; the automatic polls wait OEH_CYC instead.
          // write recovery wait
          next_post_wait  = TW'(fcs_pkg::WRR_CYC - 1);
          next_poll_limit = '0;
          next_cmd1       = fcs_pkg::CMD_READ;
          case (cmd_op_i)
            fcs_pkg::FCS_OP_PROGRAM:
            begin
              next_cmd1      = fcs_pkg::CMD_PROGRAM;
              next_two_wr    = 1'b1;
              next_post_wait = TW'(fcs_pkg::DP_CYC - 1);
            end
            fcs_pkg::FCS_OP_PROG_VFY:
            begin
              next_cmd1  = fcs_pkg::CMD_PROG_VFY;
              next_rkind = fcs_pkg::FCS_RD_SINGLE;
            end
            fcs_pkg::FCS_OP_AUTO_PROG:
            begin
              next_cmd1       = AUTO_PRG_CODE;
              next_two_wr     = 1'b1;
              next_rkind      = fcs_pkg::FCS_RD_POLL_D;
              next_post_wait  = TW'(fcs_pkg::OEH_CYC - 1);
              next_poll_limit = TW'(DAP_LIMIT - 1);
            end
            fcs_pkg::FCS_OP_ERASE:
            begin
              next_cmd1      = fcs_pkg::CMD_ERASE;
              next_wr2_data  = fcs_pkg::CMD_ERASE;
              next_two_wr    = 1'b1;
              next_post_wait = TW'(DE_CYCLES - 1);
            end
            fcs_pkg::FCS_OP_ERASE_VFY:
            begin
              next_cmd1  = fcs_pkg::CMD_ERASE_VFY;
              next_rkind = fcs_pkg::FCS_RD_SINGLE;
            end
            fcs_pkg::FCS_OP_AUTO_ERASE:
            begin
              next_cmd1       = fcs_pkg::CMD_AUTO_ERASE;
              next_wr2_data   = fcs_pkg::CMD_AUTO_ERASE;
              next_two_wr     = 1'b1;
              next_rkind      = fcs_pkg::FCS_RD_POLL_S;
              next_post_wait  = TW'(fcs_pkg::OEH_CYC - 1);
              next_poll_limit = TW'(DAE_LIMIT - 1);
            end
            fcs_pkg::FCS_OP_ABORT:
            begin
              next_cmd1     = fcs_pkg::CMD_RESET;
              next_wr2_data = fcs_pkg::CMD_RESET;
              next_two_wr   = 1'b1;
            end
            fcs_pkg::FCS_OP_READ_ID,
            fcs_pkg::FCS_OP_COMMON_ID:
            begin
              next_cmd1  = fcs_pkg::CMD_ID;
              if (cmd_op_i == fcs_pkg::FCS_OP_COMMON_ID)
              begin
                next_cmd1 = fcs_pkg::CMD_COMMON_ID;
              end
              next_rkind = fcs_pkg::FCS_RD_SINGLE;
              next_addr  = cmd_addr_i[0] ? fcs_pkg::ID_PART_ADDR
                                         : fcs_pkg::ID_MAKER_ADDR;
            end
            default:
            begin
              next_cmd1 = fcs_pkg::CMD_READ;
            end
          endcase
          if (cmd_op_i == fcs_pkg::FCS_OP_ARRAY_READ)
          begin
            next_rkind = fcs_pkg::FCS_RD_SINGLE;
            tmr_load   = 1'b1;
            tmr_count  = TW'(fcs_pkg::RD_CYC - 1);
            next_state = fcs_pkg::FCS_ST_RACC;
          end
          else
          begin
            // Command writes need the programming voltage up first.
            // raise programming voltage
            next_vpp   = 1'b1;
            tmr_load   = 1'b1;
            tmr_count  = TW'(fcs_pkg::VSC_CYC - 1);
            next_state = fcs_pkg::FCS_ST_VPP;
          end
        end
      end
      fcs_pkg::FCS_ST_VPP:
      begin
        if (tmr_exp)
        begin
          tmr_load   = 1'b1;
          tmr_count  = TW'(fcs_pkg::CS_CYC - 1);
          next_state = fcs_pkg::FCS_ST_WSET;
        end
      end
      fcs_pkg::FCS_ST_WSET:
      begin
        if (tmr_exp)
        begin
          tmr_load   = 1'b1;
          tmr_count  = TW'(fcs_pkg::WP_CYC - 1);
          next_state = fcs_pkg::FCS_ST_WPUL;
        end
      end
      fcs_pkg::FCS_ST_WPUL:
      begin
        if (tmr_exp)
        begin
          tmr_load   = 1'b1;
          tmr_count  = TW'(fcs_pkg::WPH_CYC - 1);
          next_state = fcs_pkg::FCS_ST_WHLD;
        end
      end
      fcs_pkg::FCS_ST_WHLD:
      begin
        if (tmr_exp)
        begin
          tmr_load = 1'b1;
          if (two_wr && !second)
          begin
            next_second = 1'b1;
            tmr_count   = TW'(fcs_pkg::CS_CYC - 1);
            next_state  = fcs_pkg::FCS_ST_WSET;
          end
          else
          begin
            tmr_count  = post_wait;
            poll_load  = 1'b1;
            poll_count = poll_limit;
            next_state = fcs_pkg::FCS_ST_WAIT;
          end
        end
      end
      fcs_pkg::FCS_ST_WAIT:
      begin
        if (tmr_exp)
        begin
          if (rkind == fcs_pkg::FCS_RD_NONE)
          begin
            next_state = fcs_pkg::FCS_ST_DONE;
          end
          else
          begin
            tmr_load   = 1'b1;
            tmr_count  = TW'(fcs_pkg::RD_CYC - 1);
            next_state = fcs_pkg::FCS_ST_RACC;
          end
        end
      end
      fcs_pkg::FCS_ST_RACC:
      begin
        if (tmr_exp)
        begin
          next_rdata = dq_sync;
          next_state = fcs_pkg::FCS_ST_DONE;
          if ((rkind == fcs_pkg::FCS_RD_POLL_D && dq_sync != wr2_data) ||
              (rkind == fcs_pkg::FCS_RD_POLL_S &&
               !dq_sync[fcs_pkg::TOP_BIT]))
          begin
            if (poll_exp)
            begin
              next_fail_flag = 1'b1;
            end
            else
            begin
              tmr_load   = 1'b1;
              tmr_count  = TW'(fcs_pkg::OEH_CYC - 1);
              next_state = fcs_pkg::FCS_ST_RGAP;
            end
          end
        end
      end
      fcs_pkg::FCS_ST_RGAP:
      begin
        if (tmr_exp)
        begin
          tmr_load   = 1'b1;
          tmr_count  = TW'(fcs_pkg::RD_CYC - 1);
          next_state = fcs_pkg::FCS_ST_RACC;
        end
      end
      fcs_pkg::FCS_ST_DONE:
      begin
        next_done  = 1'b1;
        next_fail  = fail_flag;
        next_busy  = 1'b0;
        next_vpp   = 1'b0;
        next_state = fcs_pkg::FCS_ST_IDLE;
      end
      default:
      begin
        next_busy  = 1'b0;
        next_vpp   = 1'b0;
        next_state = fcs_pkg::FCS_ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Address is set before the strobe falls; data spans its rise.
  // address and data timing
  assign wr_state = (next_state == fcs_pkg::FCS_ST_WSET) ||
                    (next_state == fcs_pkg::FCS_ST_WPUL) ||
                    (next_state == fcs_pkg::FCS_ST_WHLD);

  always_comb
  begin
    next_dq_oe = wr_state;
    next_dq    = next_second ? next_wr2_data : next_cmd1;
    next_we_n  = (next_state != fcs_pkg::FCS_ST_WPUL);
    next_oe_n  = (next_state != fcs_pkg::FCS_ST_RACC);
    next_ce_n  = !(wr_state || next_state == fcs_pkg::FCS_ST_RACC);
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state      <= fcs_pkg::FCS_ST_IDLE;
      rkind      <= fcs_pkg::FCS_RD_NONE;
      cmd1       <= fcs_pkg::CMD_READ;
      wr2_data   <= '0;
      two_wr     <= 1'b0;
      second     <= 1'b0;
      fail_flag  <= 1'b0;
      post_wait  <= '0;
      poll_limit <= '0;
      busy_o     <= 1'b0;
      done_o     <= 1'b0;
      fail_o     <= 1'b0;
      rdata_o    <= '0;
      fl_addr_o  <= '0;
      fl_dq_o    <= '0;
      fl_dq_oe_o <= 1'b0;
      fl_ce_n_o  <= 1'b1;
      fl_oe_n_o  <= 1'b1;
      fl_we_n_o  <= 1'b1;
      fl_vpp_o   <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      rkind      <= next_rkind;
      cmd1       <= next_cmd1;
      wr2_data   <= next_wr2_data;
      two_wr     <= next_two_wr;
      second     <= next_second;
      fail_flag  <= next_fail_flag;
      post_wait  <= next_post_wait;
      poll_limit <= next_poll_limit;
      busy_o     <= next_busy;
      done_o     <= next_done;
      fail_o     <= next_fail;
      rdata_o    <= next_rdata;
      fl_addr_o  <= next_addr;
      fl_dq_o    <= next_dq;
      fl_dq_oe_o <= next_dq_oe;
      fl_ce_n_o  <= next_ce_n;
      fl_oe_n_o  <= next_oe_n;
      fl_we_n_o  <= next_we_n;
      fl_vpp_o   <= next_vpp;
    end
  end

endmodule
`default_nettype wire

// >>> src/fcs_pkg.sv
// Constants, codes and types of the flash command sequencer host.
package fcs_pkg;

  typedef enum logic [3:0]
  {
    FCS_OP_ARRAY_READ = 4'h0,
    FCS_OP_READ_CMD   = 4'h1,
    FCS_OP_PROGRAM    = 4'h2,
    FCS_OP_PROG_VFY   = 4'h3,
    FCS_OP_AUTO_PROG  = 4'h4,
    FCS_OP_ERASE      = 4'h5,
    FCS_OP_ERASE_VFY  = 4'h6,
    FCS_OP_AUTO_ERASE = 4'h7,
    FCS_OP_ABORT      = 4'h8,
    FCS_OP_READ_ID    = 4'h9,
    FCS_OP_COMMON_ID  = 4'hA
  } fcs_op_type;

  typedef enum logic [1:0]
  {
    FCS_RD_NONE   = 2'h0,
    FCS_RD_SINGLE = 2'h1,
    FCS_RD_POLL_D = 2'h2,
    FCS_RD_POLL_S = 2'h3
  } fcs_rd_type;

  typedef enum logic [8:0]
  {
    FCS_ST_IDLE  = 9'h001,
    FCS_ST_VPP   = 9'h002,
    FCS_ST_WSET  = 9'h004,
    FCS_ST_WPUL  = 9'h008,
    FCS_ST_WHLD  = 9'h010,
    FCS_ST_WAIT  = 9'h020,
    FCS_ST_RACC  = 9'h040,
    FCS_ST_RGAP  = 9'h080,
    FCS_ST_DONE  = 9'h100
  } fcs_state_type;

  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int TMR_W  = 32;

  localparam logic [7:0] CMD_READ       = 8'h00;
  localparam logic [7:0] CMD_PROGRAM    = 8'h40;
  localparam logic [7:0] CMD_PROG_VFY   = 8'hC0;
  localparam logic [7:0] CMD_AUTO_PRG_A = 8'h10;
  localparam logic [7:0] CMD_AUTO_PRG_B = 8'h50;
  localparam logic [7:0] CMD_ERASE      = 8'h20;
  localparam logic [7:0] CMD_ERASE_VFY  = 8'hA0;
  localparam logic [7:0] CMD_AUTO_ERASE = 8'h30;
  localparam logic [7:0] CMD_RESET      = 8'hFF;
  localparam logic [7:0] CMD_ID         = 8'h80;
  localparam logic [7:0] CMD_COMMON_ID  = 8'h90;

  localparam logic [ADDR_W-1:0] ID_MAKER_ADDR = 17'h00000;
  localparam logic [ADDR_W-1:0] ID_PART_ADDR  = 17'h00001;
  localparam logic [DATA_W-1:0] ERASED_BYTE   = 8'hFF;
  localparam int TOP_BIT = DATA_W - 1;

  localparam int CLK_NS        = 10;
  localparam int T_CS_NS       = 20;
  localparam int T_WP_NS       = 60;
  localparam int T_WPH_NS      = 20;
  localparam int T_ACC_NS      = 100;
  localparam int T_OEH_NS      = 100;
  localparam int T_VSC_US      = 1;
  localparam int T_WRR_US      = 6;
  localparam int T_DP_US       = 10;
  localparam int T_DE_US       = 9500;
  localparam int T_DAP_MAX_US  = 400;
  localparam int T_DAE_MAX_MS  = 12500;
  localparam int SYNC_LAT      = 4;

  localparam int CS_CYC   = (T_CS_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WPH_CYC  = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC   = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_LAT;
  localparam int OEH_CYC  = (T_OEH_NS + CLK_NS - 1) / CLK_NS;
  localparam int VSC_CYC  = T_VSC_US * (1000 / CLK_NS);
  localparam int WRR_CYC  = T_WRR_US * (1000 / CLK_NS);
  localparam int DP_CYC   = T_DP_US * (1000 / CLK_NS);
  localparam int DE_CYC   = T_DE_US * (1000 / CLK_NS);
  localparam int DAP_CYC  = T_DAP_MAX_US * (1000 / CLK_NS);
  localparam int DAE_CYC  = T_DAE_MAX_MS * (1000000 / CLK_NS);

endpackage

// >>> src/fcs_sync.sv
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/10ps
`default_nettype none
module fcs_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] din_i,
  output var  logic [WIDTH-1:0] dout_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_dout;

  // The output follows once the second and third stages agree.
  always_comb
  begin
    next_dout = dout_o;
    if (stage2 == stage3)
    begin
      next_dout = stage3;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      dout_o <= '0;
    end
    else
    begin
      stage1 <= din_i;
      stage2 <= stage1;
      stage3 <= stage2;
      dout_o <= next_dout;
    end
  end

endmodule
`default_nettype wire

// >>> src/fcs_timer.sv
// Loadable down counter that flags expiry at zero.
`timescale 1ns/10ps
`default_nettype none
module fcs_timer #(
  parameter int WIDTH = 32
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] count_i,
  output var  logic             expired_o
);

  logic [WIDTH-1:0] cnt;
  logic [WIDTH-1:0] next_cnt;

  assign expired_o = (cnt == '0);

  // A load wins over counting; the counter rests at zero.
  always_comb
  begin
    next_cnt = cnt;
    if (load_i)
    begin
      next_cnt = count_i;
    end
    else if (cnt != '0)
    begin
      next_cnt = cnt - 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt <= '0;
    end
    else
    begin
      cnt <= next_cnt;
    end
  end

endmodule
`default_nettype wire

// >>> testbench/fcs_flash_model.sv
// Behavioural flash device that answers the host sequencer.
`timescale 1ns/10ps
`default_nettype none
module fcs_flash_model #(
  // Identifier values are arbitrary.
  parameter logic [7:0] MAKER_CODE = 8'h5A,
  parameter logic [7:0] PART_CODE  = 8'hA5,
  parameter logic [7:0] FAM_CODE   = 8'h3C,
  parameter int         PROG_NS    = 10000,
  parameter int         ERASE_NS   = 9500000,
  parameter int         WRR_NS     = 6000,
  parameter int         OEH_NS     = 100
) (
  input  wire logic [16:0] addr_i,
  input  wire logic [7:0]  dq_i,
  output var  logic [7:0]  dq_o,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        vpp_i
);
  logic [7:0]  mem [0:131071];
  logic [7:0]  cmd   = 8'h00;
  logic [7:0]  pd    = 8'h00;
  logic [16:0] wa    = 17'h00000;
  logic [16:0] va    = 17'h00000;
  logic [16:0] pa    = 17'h00000;
  logic        arm   = 1'b0;
  int          npoll = 2;
  int          polls = 0;
  time         t_rise  = 0;
  int          n_prog  = 0;
  int          n_erase = 0;
  int          n_wrr   = 0;
  initial
  begin
    foreach (mem[i]) mem[i] = 8'hFF;
    dq_o = 8'h00;
  end
  task automatic first(input logic [7:0] d);
    cmd = d;
    arm = d inside {8'h40, 8'h10, 8'h50, 8'h20, 8'h30, 8'hFF};
    va = wa;
  endtask
  task automatic second(input logic [7:0] d);
    arm = 1'b0;
    pa = wa;
    pd = d;
    polls = npoll;
    if (cmd inside {8'h40, 8'h10, 8'h50})
      mem[wa] = d;
    else if (d != cmd)
      first(d);
    else if (cmd == 8'hFF)
      cmd = 8'h00;
    else
      foreach (mem[i]) mem[i] = 8'hFF;
  endtask
  // Address on fall; no write mid-operation.
  always @(negedge we_n_i)
    if (!ce_n_i)
    begin
      wa = addr_i;
      if (!arm && cmd == 8'h40 && $time - t_rise < PROG_NS)
        n_prog++;
      if (!arm && cmd == 8'h20 && $time - t_rise < ERASE_NS)
        n_erase++;
    end
  always @(posedge we_n_i)
  begin
    if (!ce_n_i)
      t_rise = $time;
    if (!ce_n_i && !vpp_i)
      cmd = 8'h00;
    else if (!ce_n_i && arm)
      second(dq_i);
    else if (!ce_n_i)
      first(dq_i);
  end
  always @(negedge oe_n_i)
  begin
    // Read recovery after the last write.
    if ($time - t_rise <
        (cmd inside {8'h10, 8'h50, 8'h30} ? OEH_NS : WRR_NS))
      n_wrr++;
    #20;
    case (cmd)
      // Lowest address bit picks maker or part code, or maker or family code under 90h.
      8'h80, 8'h90: dq_o = !addr_i[0] ? MAKER_CODE :
                           cmd[4] ? FAM_CODE : PART_CODE;
      8'hC0: dq_o = mem[pa];
      8'hA0: dq_o = mem[va];
      8'h10, 8'h50: dq_o = polls > 0 ? ~pd : pd;
      8'h30: dq_o = polls > 0 ? 8'h00 : 8'hFF;
      default: dq_o = mem[addr_i];
    endcase
    if (polls > 0)
      polls = polls - 1;
  end
  always @(posedge oe_n_i)
    #5 dq_o = ~dq_o;
endmodule
`default_nettype wire

// >>> testbench/fcs_host_chk.sv
// Checker on the flash host sequencer ports.
`timescale 1ns/10ps
`default_nettype none
module fcs_host_chk (
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic        fail_o,
  input wire logic [16:0] fl_addr_o,
  input wire logic        fl_dq_oe_o,
  input wire logic        fl_ce_n_o,
  input wire logic        fl_oe_n_o,
  input wire logic        fl_we_n_o,
  input wire logic        fl_vpp_o
);
  logic [3:0] gap;
  logic [3:0] next_gap;
  always_comb
    next_gap = !fl_we_n_o ? 4'h0 : gap + {3'h0, gap != 4'hF};
  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
      gap <= 4'hF;
    else
      gap <= next_gap;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_write_ok:
    assert property (!fl_we_n_o |-> !fl_ce_n_o && fl_oe_n_o && fl_vpp_o)
    else $error("write outside select");
  a_vpp_setup:
    assert property ($fell(fl_we_n_o) |-> $past(fl_vpp_o, 100))
    else $error("vpp set-up short");
  a_pulse_width:
    assert property ($fell(fl_we_n_o) |-> !fl_we_n_o [*6])
    else $error("write pulse short");
  a_data_at_rise:
    assert property ($rose(fl_we_n_o) |-> !fl_ce_n_o && fl_dq_oe_o)
    else $error("data gone at strobe rise");
  a_poll_gap:
    assert property ($fell(fl_oe_n_o) |-> gap >= 4'hA)
    else $error("read too soon after write");
  a_read_clean:
    assert property (!fl_oe_n_o |-> !fl_ce_n_o && !fl_dq_oe_o && fl_we_n_o)
    else $error("bad read cycle");
  a_addr_held:
    assert property (busy_o && $past(busy_o) |-> $stable(fl_addr_o))
    else $error("address moved");
  a_fail_at_end:
    assert property (fail_o |-> done_o && !busy_o && $past(busy_o))
    else $error("fail outside end");
  a_idle_quiet:
    assert property (!busy_o && !done_o |-> fl_ce_n_o && !fl_vpp_o)
    else $error("bus active when idle");
  c_fail: cover property (fail_o);
  c_done: cover property (done_o && !fail_o);
  c_write: cover property ($fell(fl_we_n_o));
endmodule
bind fcs_host fcs_host_chk chk (.*);
`default_nettype wire

// >>> testbench/fcs_host_bench.sv
// Self-checking bench for the flash host sequencer.
`timescale 1ns/10ps
`default_nettype none
module fcs_host_bench;
  logic                mclk_i      = 1'b0;
  logic                rst_n_i     = 1'b0;
  logic                cmd_valid_i = 1'b0;
  fcs_pkg::fcs_op_type cmd_op_i    = fcs_pkg::FCS_OP_ARRAY_READ;
  logic [16:0]         cmd_addr_i  = 17'h00000;
  logic [7:0]          cmd_data_i  = 8'h00;
  logic                busy_o, done_o, fail_o, fl_dq_oe_o, gfail;
  logic                fl_ce_n_o, fl_oe_n_o, fl_we_n_o, fl_vpp_o;
  logic [16:0]         fl_addr_o;
  logic [7:0]          rdata_o, fl_dq_o, fl_dq_i, flash_q;
  int                  n_mismatch  = 0;
  int                  n_compared  = 0;
  always #5 mclk_i = ~mclk_i;
  assign fl_dq_i = fl_dq_oe_o ? fl_dq_o : flash_q;
  fcs_host #(.DE_CYCLES(200), .DAP_LIMIT(200), .DAE_LIMIT(500)) dut (.*);
  fcs_flash_model #(.ERASE_NS(2000)) flash (
    .addr_i(fl_addr_o), .dq_i(fl_dq_i), .dq_o(flash_q), .ce_n_i(fl_ce_n_o),
    .oe_n_i(fl_oe_n_o), .we_n_i(fl_we_n_o), .vpp_i(fl_vpp_o));
  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic run(input fcs_pkg::fcs_op_type op,
                     input logic [16:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge mclk_i);
    cmd_op_i = op;
    cmd_addr_i = a;
    cmd_data_i = d;
    cmd_valid_i = 1'b1;
    @(negedge mclk_i);
    cmd_valid_i = 1'b0;
    while (done_o !== 1'b1 && n < 3000)
    begin
      @(negedge mclk_i);
      n++;
    end
    chk({7'h00, done_o}, 8'h01);
    gfail = fail_o;
  endtask
  task automatic t_read_mode;
    run(fcs_pkg::FCS_OP_READ_CMD, 17'h00000, 8'h00);
    run(fcs_pkg::FCS_OP_ARRAY_READ, 17'h0ABCD, 8'h00);
    chk(rdata_o, 8'hFF);
  endtask
  task automatic t_program;
    run(fcs_pkg::FCS_OP_PROGRAM, 17'h00123, 8'h5A);
    run(fcs_pkg::FCS_OP_PROG_VFY, 17'h1FFFF, 8'h00);
    chk(rdata_o, 8'h5A);
    run(fcs_pkg::FCS_OP_ARRAY_READ, 17'h00123, 8'h00);
    chk(rdata_o, 8'h5A);
  endtask
  task automatic t_auto_prog;
    flash.npoll = 3;
    run(fcs_pkg::FCS_OP_AUTO_PROG, 17'h1F0F0, 8'h3C);
    chk(rdata_o, 8'h3C);
    chk({7'h00, gfail}, 8'h00);
    flash.npoll = 1000;
    run(fcs_pkg::FCS_OP_AUTO_PROG, 17'h00002, 8'hC3);
    chk(rdata_o, 8'h3C);
    chk({7'h00, gfail}, 8'h01);
  endtask
  task automatic t_abort;
    run(fcs_pkg::FCS_OP_ABORT, 17'h00123, 8'h00);
    run(fcs_pkg::FCS_OP_ARRAY_READ, 17'h00123, 8'h00);
    chk(rdata_o, 8'h5A);
  endtask
  task automatic t_erase;
    run(fcs_pkg::FCS_OP_ERASE, 17'h00000, 8'h00);
    run(fcs_pkg::FCS_OP_ERASE_VFY, 17'h00123, 8'h00);
    chk(rdata_o, 8'hFF);
  endtask
  task automatic t_auto_erase;
    run(fcs_pkg::FCS_OP_PROGRAM, 17'h00010, 8'h00);
    flash.npoll = 2;
    run(fcs_pkg::FCS_OP_AUTO_ERASE, 17'h00000, 8'h00);
    chk(rdata_o, 8'hFF);
    chk({7'h00, gfail}, 8'h00);
    flash.npoll = 1000;
    run(fcs_pkg::FCS_OP_AUTO_ERASE, 17'h00000, 8'h00);
    chk(rdata_o, 8'h00);
    chk({7'h00, gfail}, 8'h01);
  endtask
  task automatic t_ident;
    run(fcs_pkg::FCS_OP_READ_ID, 17'h00000, 8'h00);
    chk(rdata_o, flash.MAKER_CODE);
    run(fcs_pkg::FCS_OP_READ_ID, 17'h00001, 8'h00);
    chk(rdata_o, flash.PART_CODE);
    run(fcs_pkg::FCS_OP_COMMON_ID, 17'h00001, 8'h00);
    chk(rdata_o, flash.FAM_CODE);
  endtask
  task automatic t_timing;
    chk(8'(flash.n_prog), 8'h00);
    chk(8'(flash.n_erase), 8'h00);
    chk(8'(flash.n_wrr), 8'h00);
  endtask
  initial
  begin
    repeat (16) @(negedge mclk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    t_read_mode;
    t_program;
    t_auto_prog;
    t_abort;
    t_erase;
    t_auto_erase;
    t_ident;
    t_timing;
    wrap_up;
  end
  initial
  begin
    #600000;
    n_mismatch++;
    wrap_up;
  end
endmodule
`default_nettype wire
